// >>> logic/ihr_map.svh
`ifndef IHR_MAP_SVH
`define IHR_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IHR_A_POL     8'h43
`define IHR_A_ACT     8'h44
`define IHR_A_STL     8'h45
`define IHR_A_CP1     8'h46
`define IHR_A_CP2     8'h47
`define IHR_A_ROLE    8'h48
`define IHR_A_EVT     8'h49

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define IHR_DEFB      8'h91
`define IHR_CP1_VAL   8'h01
`define IHR_IBI_CAP   1'h1
`define IHR_POL_RST   1'h1
`define IHR_B_POL     7
`define IHR_B_SETROLE 1
`define IHR_B_ROLE    0
`define IHR_B_EVT     0
`define IHR_ZERO      8'h00
`define IHR_LEN_NONE  2'h0
`define IHR_LEN_ONE   2'h1
`define IHR_LEN_TWO   2'h2
`define IHR_CFG_RST   17'h02000

`endif

// >>> logic/ihr_pkg.sv
package ihr_pkg;

	// query kinds presented by the command engine
	typedef enum logic [1:0] {
		ihr_ccc_mxds   = 2'h0,
		ihr_ccc_status = 2'h1,
		ihr_ccc_caps   = 2'h3
	} ihr_ccc_type;

endpackage

// >>> logic/ihr_sync.sv
`timescale 1ns/100ps

// two-stage level synchroniser for quasi-static bits
module ihr_sync #(
	parameter int W = 1
) (
	// destination clock
	input  wire logic         clk,
	input  wire logic         rstn,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// refuse a zero or negative width at elaboration
	if (W < 1) begin : g_bad_width
		$error("ihr_sync: width below one");
	end

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// >>> logic/ihr_pulse_xfer.sv
`timescale 1ns/100ps

// toggle-based event crossing, one-cycle pulse out
module ihr_pulse_xfer (
	// source side
	input  wire logic src_clk,
	input  wire logic src_rstn,
	input  wire logic src_pulse,
	// destination side
	input  wire logic dst_clk,
	input  wire logic dst_rstn,
	input  wire logic dst_en,
	output logic      dst_pulse
);

	logic tog_q;
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// source toggles once per event
	always_ff @(posedge src_clk or negedge src_rstn) begin
		if (!src_rstn) begin
			tog_q <= 1'b0;
		end else if (src_pulse) begin
			tog_q <= ~tog_q;
		end
	end

	// destination holds the event while frozen
	always_ff @(posedge dst_clk or negedge dst_rstn) begin
		if (!dst_rstn) begin
			s1_q      <= 1'b0;
			s2_q      <= 1'b0;
			s3_q      <= 1'b0;
			dst_pulse <= 1'b0;
		end else if (dst_en) begin
			s1_q      <= tog_q;
			s2_q      <= s1_q;
			s3_q      <= s2_q;
			dst_pulse <= s2_q ^ s3_q;
		end
	end

endmodule

// >>> logic/ihr_regs.sv
`timescale 1ns/100ps
`include "ihr_map.svh"

module ihr_regs (
	// system clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// status high byte held elsewhere
	input  wire logic [7:0] status_msb,
	// link clock
	input  wire logic       link_clk,
	// link requests
	input  wire logic       lk_query,
	input  wire logic [1:0] lk_ccc,
	input  wire logic [7:0] lk_defbyte,
	input  wire logic       lk_acccr,
	input  wire logic       lk_role_given,
	input  wire logic       lk_tasks_done,
	input  wire logic       lk_hj_req,
	input  wire logic       lk_ibi_req,
	// link answers
	output logic            lk_reply_valid,
	output logic            lk_reply_hit,
	output logic      [1:0] lk_reply_len,
	output logic      [7:0] lk_reply_b0,
	output logic      [7:0] lk_reply_b1,
	output logic            lk_acccr_ack,
	output logic            lk_acccr_nack,
	output logic            lk_hj_ack,
	output logic            lk_ibi_ack,
	output logic            lk_return_role,
	output logic            lk_handoff_start,
	output logic            lk_role_reset,
	output logic            lk_is_ctrl
);

	// ----------------------------------------
	// system-domain state
	// ----------------------------------------
	logic [2:0]  act_q;
	logic [1:0]  stl_q;
	logic        sleep_cap_q;
	logic        pass_back_q;
	logic        policy_q;
	logic        set_role_q;
	logic        role_q;
	logic        role_chg_q;
	logic        start_p;
	logic        reset_p;
	logic        to_ctrl_p;
	logic        to_tgt_p;
	logic        wr_en;
	logic        rd_en;

	// ----------------------------------------
	// link-domain state
	// ----------------------------------------
	logic [16:0] cfg_s;
	logic [16:0] cfg_p_q;
	logic [16:0] cfg_l_q;
	logic        lk_to_ctrl_q;
	logic        lk_to_tgt_q;
	logic [2:0]  l_act;
	logic [1:0]  l_stl;
	logic [7:0]  l_msb;
	logic        l_role;
	logic        l_sleep;
	logic        l_pback;
	logic        l_pol;
	logic        l_refuse;

	assign wr_en = ce && reg_wr;
	assign rd_en = ce && reg_rd;

	function automatic logic [7:0] caps2(input logic pol, input logic slp,
			input logic pb);
		caps2 = {4'h0, pol, slp, pb, `IHR_IBI_CAP};
	endfunction

	// read decode, fixed first caps byte
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		unique case (a)
			`IHR_A_POL:  rd_mux = {policy_q, 7'h00};
			`IHR_A_ACT:  rd_mux = {5'h00, act_q};
			`IHR_A_STL:  rd_mux = {6'h00, stl_q};
			`IHR_A_CP1:  rd_mux = `IHR_CP1_VAL;
			`IHR_A_CP2:  rd_mux = caps2(policy_q, sleep_cap_q, pass_back_q);
			`IHR_A_ROLE: rd_mux = {6'h00, set_role_q, role_q};
			`IHR_A_EVT:  rd_mux = {7'h00, role_chg_q};
			default:     rd_mux = `IHR_ZERO;
		endcase
	endfunction

	// ----------------------------------------
	// software-written fields
	// ----------------------------------------

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			act_q <= 3'h0;
		end else if (wr_en && reg_addr == `IHR_A_ACT) begin
			act_q <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stl_q <= 2'h0;
		end else if (wr_en && reg_addr == `IHR_A_STL) begin
			stl_q <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleep_cap_q <= 1'b0;
			pass_back_q <= 1'b0;
		end else if (wr_en && reg_addr == `IHR_A_CP2) begin
			sleep_cap_q <= reg_wdata[2];
			pass_back_q <= reg_wdata[1];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			policy_q <= `IHR_POL_RST;
		end else if (wr_en && reg_addr == `IHR_A_POL) begin
			policy_q <= reg_wdata[`IHR_B_POL];
		end
	end

	// ----------------------------------------
	// role control
	// ----------------------------------------

	assign start_p = wr_en && reg_addr == `IHR_A_ROLE
		&& reg_wdata[`IHR_B_SETROLE] && !role_q;
	// role reset on any write with the set-role bit clear
	assign reset_p = wr_en && reg_addr == `IHR_A_ROLE
		&& !reg_wdata[`IHR_B_SETROLE];

	// role override field
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			set_role_q <= 1'b0;
		end else if (wr_en && reg_addr == `IHR_A_ROLE) begin
			set_role_q <= reg_wdata[`IHR_B_SETROLE];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			role_q <= 1'b0;
		end else if (ce) begin
			if (reset_p) begin
				role_q <= 1'b0;
			end else if (to_ctrl_p) begin
				role_q <= 1'b1;
			end else if (to_tgt_p) begin
				role_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			role_chg_q <= 1'b0;
		end else if (ce) begin
			if ((reset_p && role_q) || (to_ctrl_p && !role_q && !reset_p)
					|| (to_tgt_p && role_q && !to_ctrl_p)) begin
				role_chg_q <= 1'b1;
			end else if (wr_en && reg_addr == `IHR_A_EVT
					&& reg_wdata[`IHR_B_EVT]) begin
				role_chg_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= `IHR_ZERO;
		end else if (rd_en) begin
			reg_rdata <= rd_mux(reg_addr);
		end
	end

	// ----------------------------------------
	// domain crossings
	// ----------------------------------------

	// quasi-static settings into the link domain
	ihr_sync #(
		.W(17)
	) u_cfg (
		.clk  (link_clk),
		.rstn (rstn),
		.d    ({role_q, sleep_cap_q, pass_back_q, policy_q, stl_q, act_q,
			status_msb} ^ `IHR_CFG_RST),
		.q    (cfg_s)
	);

	// bundle taken only after two equal samples, so bits that resolve
	// in different link cycles never reach the replies as a mixed word;
	// the xor keeps all flops at zero while the policy image resets to one
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_p_q <= '0;
			cfg_l_q <= '0;
		end else begin
			cfg_p_q <= cfg_s;
			if (cfg_s == cfg_p_q) begin
				cfg_l_q <= cfg_s;
			end
		end
	end

	assign {l_role, l_sleep, l_pback, l_pol, l_stl, l_act, l_msb} = cfg_l_q ^ `IHR_CFG_RST;

	// handoff start toward the link
	ihr_pulse_xfer u_start (
		.src_clk   (clk),
		.src_rstn  (rstn),
		.src_pulse (start_p),
		.dst_clk   (link_clk),
		.dst_rstn  (rstn),
		.dst_en    (1'b1),
		.dst_pulse (lk_handoff_start)
	);

	// role reset toward the link
	ihr_pulse_xfer u_reset (
		.src_clk   (clk),
		.src_rstn  (rstn),
		.src_pulse (reset_p),
		.dst_clk   (link_clk),
		.dst_rstn  (rstn),
		.dst_en    (1'b1),
		.dst_pulse (lk_role_reset)
	);

	// role gained, back to the system side
	ihr_pulse_xfer u_to_ctrl (
		.src_clk   (link_clk),
		.src_rstn  (rstn),
		.src_pulse (lk_to_ctrl_q),
		.dst_clk   (clk),
		.dst_rstn  (rstn),
		.dst_en    (ce),
		.dst_pulse (to_ctrl_p)
	);

	// role given away, back to the system side
	ihr_pulse_xfer u_to_tgt (
		.src_clk   (link_clk),
		.src_rstn  (rstn),
		.src_pulse (lk_to_tgt_q),
		.dst_clk   (clk),
		.dst_rstn  (rstn),
		.dst_en    (ce),
		.dst_pulse (to_tgt_p)
	);

	// ----------------------------------------
	// link-side replies
	// ----------------------------------------

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lk_reply_valid <= 1'b0;
			lk_reply_hit   <= 1'b0;
			lk_reply_len   <= `IHR_LEN_NONE;
			lk_reply_b0    <= `IHR_ZERO;
			lk_reply_b1    <= `IHR_ZERO;
		end else begin
			lk_reply_valid <= lk_query;
			lk_reply_hit   <= 1'b0;
			lk_reply_len   <= `IHR_LEN_NONE;
			lk_reply_b0    <= `IHR_ZERO;
			lk_reply_b1    <= `IHR_ZERO;
			if (lk_query && lk_defbyte == `IHR_DEFB) begin
				unique case (ihr_pkg::ihr_ccc_type'(lk_ccc))
					ihr_pkg::ihr_ccc_mxds: begin
						lk_reply_hit <= 1'b1;
						lk_reply_len <= `IHR_LEN_ONE;
						lk_reply_b0  <= {5'h00, l_act};
					end
					ihr_pkg::ihr_ccc_status: begin
						lk_reply_hit <= 1'b1;
						lk_reply_len <= `IHR_LEN_TWO;
						lk_reply_b0  <= {6'h00, l_stl};
						lk_reply_b1  <= l_msb;
					end
					ihr_pkg::ihr_ccc_caps: begin
						lk_reply_hit <= 1'b1;
						lk_reply_len <= `IHR_LEN_TWO;
						lk_reply_b0  <= `IHR_CP1_VAL;
						lk_reply_b1  <= caps2(l_pol, l_sleep, l_pback);
					end
					default: begin
						lk_reply_hit <= 1'b0;
					end
				endcase
			end
		end
	end

	assign l_refuse = l_pol || l_stl[1] || l_stl[0] || l_role;

	// accept-role answer and role gain
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lk_acccr_ack  <= 1'b0;
			lk_acccr_nack <= 1'b0;
			lk_to_ctrl_q  <= 1'b0;
		end else begin
			lk_acccr_ack  <= lk_acccr && !l_refuse;
			lk_acccr_nack <= lk_acccr && l_refuse;
			lk_to_ctrl_q  <= lk_acccr && !l_refuse;
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lk_hj_ack  <= 1'b0;
			lk_ibi_ack <= 1'b0;
			lk_is_ctrl <= 1'b0;
		end else begin
			lk_hj_ack  <= lk_hj_req && l_role;
			lk_ibi_ack <= lk_ibi_req && l_role;
			lk_is_ctrl <= l_role;
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lk_return_role <= 1'b0;
			lk_to_tgt_q    <= 1'b0;
		end else begin
			lk_return_role <= lk_tasks_done && l_role && l_pback;
			lk_to_tgt_q    <= lk_role_given && l_role;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_caps1_fixed;
		@(posedge clk) disable iff (!rstn)
		rd_en && reg_addr == `IHR_A_CP1 |=> reg_rdata == `IHR_CP1_VAL;
	endproperty
	a_caps1_fixed: assert property (p_caps1_fixed)
		else $error("caps byte one not fixed");

	property p_dly_mirror;
		@(posedge clk) disable iff (!rstn)
		rd_en && reg_addr == `IHR_A_CP2 |=> reg_rdata[3] == $past(policy_q)
			&& reg_rdata[7:4] == 4'h0 && reg_rdata[0];
	endproperty
	a_dly_mirror: assert property (p_dly_mirror)
		else $error("extra-time bit not mirroring policy");

	property p_role_read;
		@(posedge clk) disable iff (!rstn)
		rd_en && reg_addr == `IHR_A_ROLE |=> reg_rdata[0] == $past(role_q)
			&& reg_rdata[7:2] == 6'h00;
	endproperty
	a_role_read: assert property (p_role_read)
		else $error("role bit read wrong");

	property p_role_flag;
		@(posedge clk) disable iff (!rstn)
		role_q != $past(role_q) |-> role_chg_q;
	endproperty
	a_role_flag: assert property (p_role_flag)
		else $error("role change flag missing");

	property p_role_reset;
		@(posedge clk) disable iff (!rstn)
		reset_p |=> !role_q;
	endproperty
	a_role_reset: assert property (p_role_reset)
		else $error("role not reset to target");

	property p_busy_nack;
		@(posedge link_clk) disable iff (!rstn)
		lk_acccr && (l_stl[1] || l_stl[0]) |=> lk_acccr_nack && !lk_acccr_ack;
	endproperty
	a_busy_nack: assert property (p_busy_nack)
		else $error("accept-role not refused while busy");

	property p_pol_ack;
		@(posedge link_clk) disable iff (!rstn)
		lk_acccr && !l_pol && l_stl == 2'h0 && !l_role |=> lk_acccr_ack;
	endproperty
	a_pol_ack: assert property (p_pol_ack)
		else $error("accept-role not acknowledged");

	property p_mxds;
		@(posedge link_clk) disable iff (!rstn)
		lk_query && lk_ccc == ihr_pkg::ihr_ccc_mxds && lk_defbyte == `IHR_DEFB
			|=> lk_reply_hit && lk_reply_b0 == {5'h00, $past(l_act)};
	endproperty
	a_mxds: assert property (p_mxds)
		else $error("activity byte reply wrong");

	property p_status;
		@(posedge link_clk) disable iff (!rstn)
		lk_query && lk_ccc == ihr_pkg::ihr_ccc_status && lk_defbyte == `IHR_DEFB
			|=> lk_reply_len == `IHR_LEN_TWO && lk_reply_b1 == $past(l_msb);
	endproperty
	a_status: assert property (p_status)
		else $error("status reply wrong");

	property p_hj_tgt;
		@(posedge link_clk) disable iff (!rstn)
		lk_hj_req && !l_role |=> !lk_hj_ack;
	endproperty
	a_hj_tgt: assert property (p_hj_tgt)
		else $error("hot-join acked as target");

	c_handoff: cover property (@(posedge clk) disable iff (!rstn) start_p);
	c_ack: cover property (@(posedge link_clk) disable iff (!rstn) lk_acccr_ack);
	c_caps: cover property (@(posedge link_clk) disable iff (!rstn)
		lk_reply_hit && lk_reply_len == `IHR_LEN_TWO);

endmodule

// >>> testbench/ihr_ctrl_model.sv
`timescale 1ns/100ps

// far-side controller: issues link requests and captures the answers
module ihr_ctrl_model (
	// link clock
	input  wire logic       link_clk,
	// requests
	output logic            lk_query,
	output logic      [1:0] lk_ccc,
	output logic      [7:0] lk_defbyte,
	output logic            lk_acccr,
	output logic            lk_role_given,
	output logic            lk_tasks_done,
	output logic            lk_hj_req,
	output logic            lk_ibi_req,
	// answers
	input  wire logic       lk_reply_valid,
	input  wire logic       lk_reply_hit,
	input  wire logic [1:0] lk_reply_len,
	input  wire logic [7:0] lk_reply_b0,
	input  wire logic [7:0] lk_reply_b1,
	input  wire logic       lk_acccr_ack,
	input  wire logic       lk_acccr_nack,
	input  wire logic       lk_hj_ack,
	input  wire logic       lk_ibi_ack,
	input  wire logic       lk_return_role
);
	logic [4:0] pulse_q;

	// request strobes: 0 accept, 1 given, 2 done, 3 hot-join, 4 ibi
	assign {lk_ibi_req, lk_hj_req, lk_tasks_done, lk_role_given, lk_acccr} = pulse_q;

	// idle values at time zero
	initial begin
		pulse_q = 5'h00;
		lk_query = 1'h0;
		lk_ccc = 2'h2;
		lk_defbyte = 8'h00;
	end

	// one query; operands scrambled once taken, reply read after its edge
	task automatic query(input logic [1:0] k, input logic [7:0] d, output logic [19:0] r);
		@(posedge link_clk);
		lk_ccc <= k;
		lk_defbyte <= d;
		lk_query <= 1'h1;
		@(posedge link_clk);
		lk_query <= 1'h0;
		lk_ccc <= ~k;
		lk_defbyte <= ~d;
		#1;
		r = {lk_reply_valid, lk_reply_hit, lk_reply_len, lk_reply_b0, lk_reply_b1};
	endtask

	// one request pulse; answer flags {ack, nack, hj ack, ibi ack, return}
	task automatic req(input int n, output logic [4:0] a);
		@(posedge link_clk);
		pulse_q[n] <= 1'h1;
		@(posedge link_clk);
		pulse_q[n] <= 1'h0;
		#1;
		a = {lk_acccr_ack, lk_acccr_nack, lk_hj_ack, lk_ibi_ack, lk_return_role};
	endtask

	task automatic poll_ready(input int lim, output int n);
		logic [19:0] r;
		n = 0;
		r = 20'h00200;
		while (r[9] && n < lim) begin
			query(ihr_pkg::ihr_ccc_status, 8'h91, r);
			n++;
		end
	endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
`include "ihr_map.svh"

// self-checking bench for the handoff register group
module tb;
	// ----------------------------------------
	// signals and counters
	// ----------------------------------------
	logic       clk, link_clk, rstn, ce, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, status_msb;
	logic       lk_query, lk_acccr, lk_role_given, lk_tasks_done, lk_hj_req, lk_ibi_req;
	logic [1:0] lk_ccc, lk_reply_len;
	logic [7:0] lk_defbyte, lk_reply_b0, lk_reply_b1;
	logic       lk_reply_valid, lk_reply_hit, lk_acccr_ack, lk_acccr_nack, lk_hj_ack;
	logic       lk_ibi_ack, lk_return_role, lk_handoff_start, lk_role_reset, lk_is_ctrl;
	int         err_total, checks_done, n_hs, n_rr;

	ihr_regs dut (.clk, .rstn, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.status_msb, .link_clk, .lk_query, .lk_ccc, .lk_defbyte, .lk_acccr, .lk_role_given,
		.lk_tasks_done, .lk_hj_req, .lk_ibi_req, .lk_reply_valid, .lk_reply_hit,
		.lk_reply_len, .lk_reply_b0, .lk_reply_b1, .lk_acccr_ack, .lk_acccr_nack,
		.lk_hj_ack, .lk_ibi_ack, .lk_return_role, .lk_handoff_start, .lk_role_reset,
		.lk_is_ctrl);

	ihr_ctrl_model mdl (.link_clk, .lk_query, .lk_ccc, .lk_defbyte, .lk_acccr,
		.lk_role_given, .lk_tasks_done, .lk_hj_req, .lk_ibi_req, .lk_reply_valid,
		.lk_reply_hit, .lk_reply_len, .lk_reply_b0, .lk_reply_b1, .lk_acccr_ack,
		.lk_acccr_nack, .lk_hj_ack, .lk_ibi_ack, .lk_return_role);

	// ----------------------------------------
	// clocks, pulse counters, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		link_clk = 1'h0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	always @(posedge link_clk) begin
		if (lk_handoff_start === 1'h1) n_hs++;
		if (lk_role_reset === 1'h1) n_rr++;
	end
	initial begin
		#60000;
		err_total++;
		$display("[ERR] watchdog expired");
		complete_run();
	end

	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task automatic report(input string nm, input logic [19:0] e, input logic [19:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		report(nm, {12'h000, e}, {12'h000, g});
	endtask
	task automatic chk_ans(input string nm, input logic [19:0] e, input logic [19:0] g);
		report(nm, e, g);
	endtask
	task automatic chk_num(input string nm, input int e, input int g);
		report(nm, e[19:0], g[19:0]);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic c = 1'h1);
		@(posedge clk);
		ce <= c;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		ce <= 1'h1;
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk_reg($sformatf("reg %h", a), e, reg_rdata);
	endtask
	// settings cross through two-stage synchronisers
	task automatic sync();
		repeat (5) @(posedge link_clk);
	endtask
	// query reply; bytes past the stated length are not compared
	task automatic qchk(input logic [1:0] k, input logic [7:0] d, input logic [19:0] e);
		logic [19:0] r;
		mdl.query(k, d, r);
		if (e[17:16] != 2'h2) r[7:0] = e[7:0];
		if (e[17:16] == 2'h0) r[15:8] = e[15:8];
		chk_ans("reply", e, r);
	endtask
	task automatic lreq(input int n, input logic [4:0] e);
		logic [4:0] a;
		mdl.req(n, a);
		chk_ans("answer", {15'h0000, e}, {15'h0000, a});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd_exp(`IHR_A_POL, 8'h80);  // policy starts as refuse
		rd_exp(`IHR_A_ACT, 8'h00);  // state field clear
		rd_exp(`IHR_A_STL, 8'h00);  // status clear
		rd_exp(`IHR_A_CP1, 8'h01);  // fixed caps byte
		rd_exp(`IHR_A_CP2, 8'h09);  // mirror and ibi
		rd_exp(`IHR_A_ROLE, 8'h00); // starts as target
		rd_exp(`IHR_A_EVT, 8'h00);  // no change yet
		$display("test reset values done");
	endtask

	task automatic t_fields();
		wr(`IHR_A_ACT, 8'hFF);
		rd_exp(`IHR_A_ACT, 8'h07);       // only low bits kept
		wr(`IHR_A_STL, 8'hFF);
		rd_exp(`IHR_A_STL, 8'h03);       // upper bits zero
		wr(`IHR_A_CP1, 8'hFE);
		rd_exp(`IHR_A_CP1, 8'h01);       // write ignored
		wr(`IHR_A_CP2, 8'hF6);
		rd_exp(`IHR_A_CP2, 8'h0F);       // writable bits
		wr(`IHR_A_POL, 8'h7F);
		rd_exp(`IHR_A_POL, 8'h00);       // policy cleared
		rd_exp(`IHR_A_CP2, 8'h07);       // follows policy
		wr(8'h50, 8'hFF);
		rd_exp(8'h50, 8'h00);            // unmapped reads zero
		wr(`IHR_A_ACT, 8'h00, 1'h0);
		rd_exp(`IHR_A_ACT, 8'h07);       // frozen write ignored
		wr(`IHR_A_ACT, 8'h05);
		wr(`IHR_A_STL, 8'h02);
		$display("test register fields done");
	endtask

	task automatic t_query();
		sync();
		qchk(ihr_pkg::ihr_ccc_mxds, 8'h91, 20'hD0500);   // activity byte
		qchk(ihr_pkg::ihr_ccc_status, 8'h91, 20'hE02A5); // low then high
		qchk(ihr_pkg::ihr_ccc_caps, 8'h91, 20'hE0107);   // both caps bytes
		qchk(ihr_pkg::ihr_ccc_status, 8'h90, 20'h80000); // other defining byte
		qchk(2'h2, 8'h91, 20'h80000);                     // illegal kind
		$display("test queries done");
	endtask

	task automatic t_accept();
		int n;
		lreq(0, 5'h08);                  // busy refuses
		mdl.poll_ready(3, n);
		chk_num("polls", 3, n);          // still busy
		wr(`IHR_A_STL, 8'h01);
		sync();
		lreq(0, 5'h08);                  // slept refuses
		wr(`IHR_A_STL, 8'h00);
		wr(`IHR_A_POL, 8'h80);
		sync();
		lreq(0, 5'h08);                  // policy refuses
		lreq(3, 5'h00);                  // no hot-join ack as target
		lreq(4, 5'h00);                  // no ibi ack as target
		wr(`IHR_A_POL, 8'h00);
		sync();
		mdl.poll_ready(3, n);
		chk_num("polls", 1, n);          // ready at once
		lreq(0, 5'h10);                  // accepted
		for (int i = 0; i < 20 && lk_is_ctrl !== 1'h1; i++) @(posedge clk);
		chk_reg("is ctrl", 8'h01, {7'h00, lk_is_ctrl}); // link sees controller
		rd_exp(`IHR_A_ROLE, 8'h01);      // now controller
		rd_exp(`IHR_A_EVT, 8'h01);       // change flagged
		$display("test accept role done");
	endtask

	task automatic t_ctrl();
		lreq(3, 5'h04);                  // hot-join acked
		lreq(4, 5'h02);                  // ibi acked
		lreq(2, 5'h01);                  // role passed back
		lreq(0, 5'h08);                  // already controller
		wr(`IHR_A_EVT, 8'h01);
		rd_exp(`IHR_A_EVT, 8'h00);       // write one clears
		lreq(1, 5'h00);                  // role handed away
		for (int i = 0; i < 20 && lk_is_ctrl !== 1'h0; i++) @(posedge clk);
		chk_reg("is ctrl", 8'h00, {7'h00, lk_is_ctrl}); // link sees target
		rd_exp(`IHR_A_ROLE, 8'h00);      // back to target
		rd_exp(`IHR_A_EVT, 8'h01);       // change flagged again
		$display("test controller duties done");
	endtask

	task automatic t_override();
		int hs0;
		int rr0;
		hs0 = n_hs;
		rr0 = n_rr;
		wr(`IHR_A_ROLE, 8'h02);
		repeat (8) @(posedge link_clk);
		chk_num("handoff starts", hs0 + 1, n_hs); // one start
		rd_exp(`IHR_A_ROLE, 8'h02);               // request held
		wr(`IHR_A_ROLE, 8'h00);
		repeat (8) @(posedge link_clk);
		chk_num("role resets", rr0 + 1, n_rr);    // one reset
		rd_exp(`IHR_A_ROLE, 8'h00);               // target
		wr(`IHR_A_EVT, 8'h01);
		lreq(0, 5'h10);                           // accepted again
		for (int i = 0; i < 20 && lk_is_ctrl !== 1'h1; i++) @(posedge clk);
		chk_reg("is ctrl", 8'h01, {7'h00, lk_is_ctrl}); // controller again
		wr(`IHR_A_ROLE, 8'h00);
		rd_exp(`IHR_A_ROLE, 8'h00);               // forced back to target
		rd_exp(`IHR_A_EVT, 8'h01);                // reset counts as change
		$display("test role override done");
	endtask

	// ends the run with the verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// reset, then the scenarios in order
	initial begin
		err_total = 0;
		checks_done = 0;
		n_hs = 0;
		n_rr = 0;
		rstn = 1'h0;
		ce = 1'h1;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		status_msb = 8'hA5;
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		t_reset();
		t_fields();
		t_query();
		t_accept();
		t_ctrl();
		t_override();
		complete_run();
	end
endmodule
